// ===== hdl/dtc_divider.sv
// Divides the system clock by 12 or 4 into one-cycle ticks.
// Assumes i_fast may change at any time; the count wraps safely.
`timescale 1ns/1ps
`default_nettype none

module dtc_divider
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Ratio select and tick
  input  wire logic i_fast,
  output logic      o_tick
);
  import dtc_pkg::*;

  logic [3:0] cnt_reg;
  logic [3:0] last;

  // Terminal count of the chosen ratio
  assign last = (i_fast ? DIV_FAST : DIV_SLOW) - 4'h1;

  // ****************************************
  // Counter
  // ****************************************
  // >= guards a switch from slow to fast mid-count
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      cnt_reg <= 4'h0;
    else if (cnt_reg >= last)
      cnt_reg <= 4'h0;
    else
      cnt_reg <= cnt_reg + 4'h1;
  end

  assign o_tick = (cnt_reg == last);

  slow_gap_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (o_tick && !i_fast) ##1 !i_fast [*8] |-> !o_tick)
    else $error("slow tick came early");

endmodule : dtc_divider

`default_nettype wire

// ===== hdl/dtc_falling_edge.sv
// Samples one external pin each clock and flags falling edges.
// Assumes the pin is already synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none

module dtc_falling_edge
(
  // Clock and reset
  input  wire logic i_clk,
  input  wire logic i_resetn,
  // Pin and edge
  input  wire logic i_pin,
  output logic      o_fall
);
  import dtc_pkg::*;

  logic sample_reg;
  logic prev_reg;

  // ****************************************
  // Sampling
  // ****************************************
  // Reset to high so a pin held low gives one edge after reset
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      sample_reg <= 1'b1;
      prev_reg   <= 1'b1;
    end
    else
    begin
      sample_reg <= i_pin;
      prev_reg   <= sample_reg;
    end
  end

  assign o_fall = prev_reg & ~sample_reg;

  fall_once_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
    o_fall |=> !o_fall) else $error("edge flagged twice");

endmodule : dtc_falling_edge

`default_nettype wire

// ===== hdl/dtc_top.sv
// Dual 16-bit timer/counter unit with register port and interrupt.
// Assumes count and gate pins are synchronous to i_clk and that
// the processor pulses the service-entry inputs once per entry.
//
// Overview of operation
// - Timer mode counts every twelve clocks
// - Counter mode counts sampled pin falling edges
// - Service entry clears the overflow flag
// - Run bit enables; clearing holds count
// - Gate bit qualifies counting with gate pin
// - Counter-select picks pin or divided clock
// - Mode 0: 5-bit prescaler, 13-bit counter
// - Mode 1: cascaded 16-bit counter
// - Mode 2: 8-bit counter reloads from high
// - Mode 3 splits first timer in two
// - Second divider bit picks four or twelve
// - First divider bit picks four or twelve
// - Split high byte uses second timer controls
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module dtc_top
(
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_resetn,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // External pins
  input  wire logic       i_timer_a_input_pin,
  input  wire logic       i_timer_b_input_pin,
  input  wire logic       i_timer_a_gate_pin,
  input  wire logic       i_timer_b_gate_pin,
  // Service routine entry pulses
  input  wire logic       i_timer_a_isr_enter,
  input  wire logic       i_timer_b_isr_enter,
  // Flags and interrupt
  output logic            o_timer_a_overflow_flag,
  output logic            o_timer_b_overflow_flag,
  output logic            o_irq
);
  import dtc_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [7:0] control_reg;
  logic [7:0] mode_reg;
  logic [7:0] divider_reg;
  logic [7:0] a_low_reg;
  logic [7:0] a_high_reg;
  logic [7:0] b_low_reg;
  logic [7:0] b_high_reg;
  logic [1:0] int_stat_reg;
  logic [1:0] int_mask_reg;
  logic       flag_a_reg;
  logic       flag_b_reg;
  logic [7:0] rdata_reg;
  logic       irq_reg;

  logic       tick_a;
  logic       tick_b;
  logic       fall_a;
  logic       fall_b;
  logic       en_a;
  logic       en_b;
  logic       inc_a;
  logic       inc_a_hi;
  logic       inc_b;
  logic       split;
  dtc_mode_t  mode_a;
  dtc_mode_t  mode_b;
  logic [16:0] step_a;
  logic [16:0] step_b;
  logic [7:0] a_low_next;
  logic [7:0] a_high_next;
  logic [7:0] b_low_next;
  logic [7:0] b_high_next;
  logic       ovf_a;
  logic       ovf_b;
  logic [7:0] rdata_next;

  logic wr_ctl;
  logic wr_a_lo;
  logic wr_a_hi;
  logic wr_b_lo;
  logic wr_b_hi;

  assign wr_ctl  = i_wr && (i_addr == OFS_CONTROL);
  assign wr_a_lo = i_wr && (i_addr == OFS_A_LOW);
  assign wr_a_hi = i_wr && (i_addr == OFS_A_HIGH);
  assign wr_b_lo = i_wr && (i_addr == OFS_B_LOW);
  assign wr_b_hi = i_wr && (i_addr == OFS_B_HIGH);

  // ****************************************
  // Clock sources
  // ****************************************
  dtc_divider u_div_a
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_fast   (divider_reg[DIV_A_SEL]),
    .o_tick   (tick_a)
  );

  dtc_divider u_div_b
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_fast   (divider_reg[DIV_B_SEL]),
    .o_tick   (tick_b)
  );

  dtc_falling_edge u_edge_a
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_pin    (i_timer_a_input_pin),
    .o_fall   (fall_a)
  );

  dtc_falling_edge u_edge_b
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_pin    (i_timer_b_input_pin),
    .o_fall   (fall_b)
  );

  // ****************************************
  // Count enables
  // ****************************************
  // Run bit, then optional gate pin level
  assign mode_a = dtc_mode_t'(mode_reg[MOD_A_MHI:MOD_A_MLO]);
  assign mode_b = dtc_mode_t'(mode_reg[MOD_B_MHI:MOD_B_MLO]);
  assign split  = (mode_a == DTC_SPLIT);
  assign en_a   = control_reg[CTL_A_RUN] &&
                  (!mode_reg[MOD_A_GATE] || i_timer_a_gate_pin);
  assign en_b   = control_reg[CTL_B_RUN] &&
                  (!mode_reg[MOD_B_GATE] || i_timer_b_gate_pin);
  assign inc_a  = en_a &&
                  (mode_reg[MOD_A_CSEL] ? fall_a : tick_a);
  assign inc_b  = en_b &&
                  (mode_reg[MOD_B_CSEL] ? fall_b : tick_b);
  // Split high byte is a pure timer on the second controls
  assign inc_a_hi = en_b && tick_a;

  // One increment step for modes 0..2; returns {ovf, high, low}
  function automatic logic [16:0] dtc_step(input dtc_mode_t m,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (m)
      DTC_MODE13:
      begin
        r[4:0] = lo[4:0] + 5'h1;
        if (lo[4:0] == PRESCALE_TOP)
        begin
          r[15:8] = hi + 8'h1;
          r[16]   = (hi == BYTE_ONES);
        end
      end
      DTC_MODE16:
        r = {1'b0, hi, lo} + 17'h1;
      DTC_MODE8R:
      begin
        if (lo == BYTE_ONES)
        begin
          r[7:0] = hi;
          r[16]  = 1'b1;
        end
        else
          r[7:0] = lo + 8'h1;
      end
      default:
        r = {1'b0, hi, lo}; // Split not allowed here: hold
    endcase
    return r;
  endfunction : dtc_step

  assign step_a = dtc_step(mode_a, a_low_reg, a_high_reg);
  assign step_b = dtc_step(mode_b, b_low_reg, b_high_reg);

  // ****************************************
  // Next count values
  // ****************************************
  // Software load beats a count in the same cycle
  always_comb
  begin
    a_low_next  = a_low_reg;
    a_high_next = a_high_reg;
    ovf_a       = 1'b0;
    ovf_b       = 1'b0;
    if (split)
    begin
      if (inc_a)
      begin
        a_low_next = a_low_reg + 8'h1;
        ovf_a      = (a_low_reg == BYTE_ONES);
      end
      if (inc_a_hi)
      begin
        a_high_next = a_high_reg + 8'h1;
        ovf_b       = (a_high_reg == BYTE_ONES);
      end
    end
    else if (inc_a)
    begin
      a_low_next  = step_a[7:0];
      a_high_next = step_a[15:8];
      ovf_a       = step_a[16];
    end
    b_low_next  = b_low_reg;
    b_high_next = b_high_reg;
    if (inc_b)
    begin
      b_low_next  = step_b[7:0];
      b_high_next = step_b[15:8];
      // Second flag belongs to the split high byte
      if (!split)
        ovf_b = step_b[16];
    end
    if (wr_a_lo)
      a_low_next = i_wdata;
    if (wr_a_hi)
      a_high_next = i_wdata;
    if (wr_b_lo)
      b_low_next = i_wdata;
    if (wr_b_hi)
      b_high_next = i_wdata;
  end

  // Count registers
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      a_low_reg  <= BYTE_ZERO;
      a_high_reg <= BYTE_ZERO;
      b_low_reg  <= BYTE_ZERO;
      b_high_reg <= BYTE_ZERO;
    end
    else
    begin
      a_low_reg  <= a_low_next;
      a_high_reg <= a_high_next;
      b_low_reg  <= b_low_next;
      b_high_reg <= b_high_next;
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Low control bits are stored but drive nothing here
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      control_reg <= BYTE_ZERO;
      mode_reg    <= BYTE_ZERO;
      divider_reg <= DIVIDER_RESET;
    end
    else
    begin
      if (wr_ctl)
        control_reg <= i_wdata;
      if (i_wr && (i_addr == OFS_MODE))
        mode_reg <= i_wdata;
      if (i_wr && (i_addr == OFS_DIVIDER))
        divider_reg <= i_wdata;
    end
  end

  // ****************************************
  // Overflow flags
  // ****************************************
  // Overflow set wins over service clear and software write
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      flag_a_reg <= 1'b0;
      flag_b_reg <= 1'b0;
    end
    else
    begin
      if (ovf_a)
        flag_a_reg <= 1'b1;
      else if (wr_ctl)
        flag_a_reg <= i_wdata[CTL_A_FLAG];
      else if (i_timer_a_isr_enter)
        flag_a_reg <= 1'b0;
      if (ovf_b)
        flag_b_reg <= 1'b1;
      else if (wr_ctl)
        flag_b_reg <= i_wdata[CTL_B_FLAG];
      else if (i_timer_b_isr_enter)
        flag_b_reg <= 1'b0;
    end
  end

  // ****************************************
  // Interrupt status and mask
  // ****************************************
  // Write one to clear; a new overflow wins
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      int_stat_reg <= INT_MASK_RESET;
      int_mask_reg <= INT_MASK_RESET;
      irq_reg      <= 1'b0;
    end
    else
    begin
      if (i_wr && (i_addr == OFS_INT_STAT))
        int_stat_reg <= (int_stat_reg & ~i_wdata[1:0]) | {ovf_b, ovf_a};
      else
        int_stat_reg <= int_stat_reg | {ovf_b, ovf_a};
      if (i_wr && (i_addr == OFS_INT_MASK))
        int_mask_reg <= i_wdata[1:0];
      irq_reg <= |(int_stat_reg & int_mask_reg);
    end
  end

  // ****************************************
  // Read path
  // ****************************************
  // Unmapped addresses read zero
  always_comb
  begin
    rdata_next = BYTE_ZERO;
    case (i_addr)
      OFS_CONTROL:
      begin
        rdata_next             = control_reg;
        rdata_next[CTL_A_FLAG] = flag_a_reg;
        rdata_next[CTL_B_FLAG] = flag_b_reg;
      end
      OFS_MODE:     rdata_next = mode_reg;
      OFS_A_LOW:    rdata_next = a_low_reg;
      OFS_A_HIGH:   rdata_next = a_high_reg;
      OFS_B_LOW:    rdata_next = b_low_reg;
      OFS_B_HIGH:   rdata_next = b_high_reg;
      OFS_DIVIDER:  rdata_next = divider_reg;
      OFS_INT_STAT: rdata_next = {6'h00, int_stat_reg};
      OFS_INT_MASK: rdata_next = {6'h00, int_mask_reg};
      default:      rdata_next = BYTE_ZERO;
    endcase
  end

  // Data stand one cycle after the strobe only
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      rdata_reg <= BYTE_ZERO;
    else if (i_rd)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= BYTE_ZERO;
  end

  assign o_rdata                 = rdata_reg;
  assign o_irq                   = irq_reg;
  assign o_timer_a_overflow_flag = flag_a_reg;
  assign o_timer_b_overflow_flag = flag_b_reg;

  // ****************************************
  // Checks
  // ****************************************
  default clocking dtc_cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence a_quiet_s;
    !i_wr && !split && mode_a == DTC_MODE16;
  endsequence

  run_halt_a: assert property (a_quiet_s and !control_reg[CTL_A_RUN]
    |=> $stable({a_high_reg, a_low_reg}))
    else $error("halted timer moved");
  timer_inc_a: assert property (a_quiet_s and !mode_reg[MOD_A_CSEL]
    and en_a and tick_a |=> {a_high_reg, a_low_reg} ==
    $past({a_high_reg, a_low_reg}) + 16'h1)
    else $error("timer tick missed");
  gate_hold_a: assert property (a_quiet_s and mode_reg[MOD_A_GATE]
    and !i_timer_a_gate_pin |=> $stable(a_low_reg))
    else $error("gated timer moved");
  pin_count_a: assert property (a_quiet_s and mode_reg[MOD_A_CSEL]
    and !fall_a |=> $stable(a_low_reg))
    else $error("count without edge");
  wrap_flag_a: assert property (!i_wr && !split && inc_a
    && mode_a == DTC_MODE16 && {a_high_reg, a_low_reg} == 16'hFFFF
    |=> flag_a_reg && a_low_reg == BYTE_ZERO && a_high_reg == BYTE_ZERO)
    else $error("wrap flag missing");
  reload_low_a: assert property (!i_wr && inc_a && mode_a == DTC_MODE8R
    && a_low_reg == BYTE_ONES |=> a_low_reg == $past(a_high_reg))
    else $error("reload wrong");
  prescale_a: assert property (!i_wr && inc_a && mode_a == DTC_MODE13
    && a_low_reg[4:0] != PRESCALE_TOP |=> $stable(a_high_reg))
    else $error("prescaler leaked");
  split_high_a: assert property (!i_wr && split && inc_a_hi
    && a_high_reg == BYTE_ONES |=> flag_b_reg)
    else $error("split flag missing");
  isr_clear_a: assert property (i_timer_a_isr_enter && !ovf_a && !wr_ctl
    |=> !flag_a_reg)
    else $error("flag not cleared");
  load_read_a: assert property (wr_a_lo ##1 i_rd && i_addr == OFS_A_LOW
    && !wr_a_lo && !inc_a |=> o_rdata == $past(i_wdata, 2))
    else $error("load not read back");

endmodule : dtc_top

`default_nettype wire

// ===== pkg/dtc_pkg.sv
// Constants shared by the dual timer/counter unit.
// Assumes an 8-bit register port and a single system clock.
`default_nettype none

package dtc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_CONTROL  = 8'h88;
  localparam logic [7:0] OFS_MODE     = 8'h89;
  localparam logic [7:0] OFS_A_LOW    = 8'h8A;
  localparam logic [7:0] OFS_B_LOW    = 8'h8B;
  localparam logic [7:0] OFS_A_HIGH   = 8'h8C;
  localparam logic [7:0] OFS_B_HIGH   = 8'h8D;
  localparam logic [7:0] OFS_DIVIDER  = 8'h8E;
  localparam logic [7:0] OFS_INT_STAT = 8'h90;
  localparam logic [7:0] OFS_INT_MASK = 8'h91;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int CTL_B_FLAG = 7;
  localparam int CTL_B_RUN  = 6;
  localparam int CTL_A_FLAG = 5;
  localparam int CTL_A_RUN  = 4;
  localparam int MOD_B_GATE = 7;
  localparam int MOD_B_CSEL = 6;
  localparam int MOD_B_MHI  = 5;
  localparam int MOD_B_MLO  = 4;
  localparam int MOD_A_GATE = 3;
  localparam int MOD_A_CSEL = 2;
  localparam int MOD_A_MHI  = 1;
  localparam int MOD_A_MLO  = 0;
  localparam int DIV_B_SEL  = 4;
  localparam int DIV_A_SEL  = 3;
  localparam int INT_A      = 0;
  localparam int INT_B      = 1;
  localparam logic [7:0] DIVIDER_RESET = 8'hC0;
  localparam logic [7:0] BYTE_ZERO     = 8'h00;
  localparam logic [7:0] BYTE_ONES     = 8'hFF;
  localparam logic [4:0] PRESCALE_TOP  = 5'h1F;
  localparam logic [1:0] INT_MASK_RESET = 2'h0;

  // ****************************************
  // Clock division ratios (system clock 50 ns)
  // ****************************************
  localparam logic [3:0] DIV_SLOW = 4'hC;
  localparam logic [3:0] DIV_FAST = 4'h4;

  // Counting modes
  typedef enum logic [1:0] {
    DTC_MODE13 = 2'b00,
    DTC_MODE16 = 2'b01,
    DTC_MODE8R = 2'b10,
    DTC_SPLIT  = 2'b11
  } dtc_mode_t;

endpackage : dtc_pkg

`default_nettype wire

// ===== verif/dtc_pin_model.sv
// Model of the external count and gate pins of both timers.
// Assumes one-cycle request pulses from the bench on i_clk.
`timescale 1ns/1ps
`default_nettype none

module dtc_pin_model
#(
  parameter int LOW_HOLD = 3
)
(
  // Clock and requests
  input  wire logic       i_clk,
  input  wire logic [1:0] i_fall_req,
  input  wire logic [1:0] i_gate_req,
  // Pins
  output logic      [1:0] o_count_pin,
  output logic      [1:0] o_gate_pin
);
  // ****************************************
  // Pin drivers
  // ****************************************
  int low_cnt [2];

  // Low phase held several clocks so one sample per clock sees it
  always_ff @(posedge i_clk)
  begin
    for (int k = 0; k < 2; k++)
    begin
      if (i_fall_req[k])
        low_cnt[k] <= LOW_HOLD;
      else if (low_cnt[k] > 0)
        low_cnt[k] <= low_cnt[k] - 1;
    end
  end

  // Idle high, like a pulled-up line
  assign o_count_pin[0] = (low_cnt[0] == 0);
  assign o_count_pin[1] = (low_cnt[1] == 0);

  // Gate levels change just after an edge, as a slow pin would
  always_ff @(posedge i_clk)
  begin
    o_gate_pin <= i_gate_req;
  end
endmodule : dtc_pin_model

`default_nettype wire

// ===== verif/dtc_top_tb_top.sv
// Self-checking bench for the dual timer/counter unit.
// Assumes the pin model above and a 50 ns system clock.
`timescale 1ns/1ps
`default_nettype none

module dtc_top_tb_top;
  import dtc_pkg::*;

  // ****************************************
  // Signals and instances
  // ****************************************
  logic       clk;
  logic       resetn;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr_s;
  logic       rd_s;
  logic [7:0] rdata;
  logic [1:0] cnt_pin;
  logic [1:0] gate_pin;
  logic [1:0] isr;
  logic       flag_a;
  logic       flag_b;
  logic       irq;
  logic [1:0] fall_req;
  logic [1:0] gate_req;
  int         fail_count;
  int         n_checks;
  int         cycles;

  dtc_top i_dut (
    .i_clk                   (clk),
    .i_resetn                (resetn),
    .i_addr                  (addr),
    .i_wdata                 (wdata),
    .i_wr                    (wr_s),
    .i_rd                    (rd_s),
    .o_rdata                 (rdata),
    .i_timer_a_input_pin     (cnt_pin[0]),
    .i_timer_b_input_pin     (cnt_pin[1]),
    .i_timer_a_gate_pin      (gate_pin[0]),
    .i_timer_b_gate_pin      (gate_pin[1]),
    .i_timer_a_isr_enter     (isr[0]),
    .i_timer_b_isr_enter     (isr[1]),
    .o_timer_a_overflow_flag (flag_a),
    .o_timer_b_overflow_flag (flag_b),
    .o_irq                   (irq)
  );

  dtc_pin_model i_pins (
    .i_clk       (clk),
    .i_fall_req  (fall_req),
    .i_gate_req  (gate_req),
    .o_count_pin (cnt_pin),
    .o_gate_pin  (gate_pin)
  );

  // Clock of 50 ns
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Hang guard, well above the several hundred cycles expected
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
                        input string what);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    chk(what, {8'h00, exp}, {8'h00, rdata});
  endtask : rd_chk

  // Plain read; data taken in the cycle in which they stand
  task automatic rd_get(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask : rd_get

  function automatic logic flag(input bit b);
    return b ? flag_b : flag_a;
  endfunction : flag

  task automatic isr_pulse(input bit b);
    @(posedge clk);
    isr[b] <= 1'b1;
    @(posedge clk);
    isr[b] <= 1'b0;
  endtask : isr_pulse

  // Counts negedges until the flag shows, bounded
  task automatic wait_flag(input bit b, output int n);
    n = 0;
    while (flag(b) !== 1'b1 && n < 400)
    begin
      @(negedge clk);
      n++;
    end
  endtask : wait_flag

  // Cycles from one wrap to the next, flag cleared by service entry
  task automatic period(input bit b, input int exp);
    int n;
    isr_pulse(b);
    isr_pulse(b);
    wait_flag(b, n);
    isr_pulse(b);
    @(negedge clk);
    chk("flag after entry", 16'h0, {15'h0, flag(b)});
    wait_flag(b, n);
    n = n + 2;
    chk("wrap period", exp[15:0], n[15:0]);
  endtask : period

  task automatic falls(input logic [1:0] m, input int cnt);
    repeat (cnt)
    begin
      @(posedge clk);
      fall_req <= m;
      @(posedge clk);
      fall_req <= 2'b00;
      repeat (6) @(posedge clk);
    end
  endtask : falls

  // ****************************************
  // Test sequence
  // ****************************************
  initial
  begin
    int n;
    logic [7:0] v;
    resetn = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr_s = 1'b0;
    rd_s = 1'b0;
    isr = 2'b00;
    fall_req = 2'b00;
    gate_req = 2'b00;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    rd_chk(OFS_DIVIDER, DIVIDER_RESET, "divider");
    rd_chk(OFS_CONTROL, BYTE_ZERO, "control");
    rd_chk(OFS_INT_MASK, BYTE_ZERO, "mask");
    wr(8'h87, 8'hA5);
    rd_chk(8'h87, BYTE_ZERO, "unmapped");
    for (int i = 0; i < 4; i++)
    begin
      rd_chk(OFS_A_LOW + 8'(i), BYTE_ZERO, "count reset");
      wr(OFS_A_LOW + 8'(i), 8'h5A ^ 8'(i));
      rd_chk(OFS_A_LOW + 8'(i), 8'h5A ^ 8'(i), "count");
      wr(OFS_A_LOW + 8'(i), BYTE_ZERO);
    end
    $display("test registers done");

    // A counts pin edges; B gated counter held by a low gate
    wr(OFS_MODE, 8'hD5);
    wr(OFS_CONTROL, 8'h50);
    falls(2'b11, 3);
    rd_chk(OFS_A_LOW, 8'h03, "pin count a");
    rd_chk(OFS_B_LOW, 8'h00, "gated b");
    @(posedge clk);
    gate_req <= 2'b10;
    falls(2'b10, 2);
    rd_chk(OFS_B_LOW, 8'h02, "open gate b");
    $display("test counter done");

    // Counter mode ignores ticks; clearing the run bit freezes a timer
    wr(OFS_MODE, 8'h05);
    repeat (40) @(posedge clk);
    rd_chk(OFS_A_LOW, 8'h03, "no tick in counter mode");
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_MODE, 8'h01);
    wr(OFS_A_LOW, BYTE_ZERO);
    wr(OFS_CONTROL, 8'h10);
    repeat (36) @(posedge clk);
    wr(OFS_CONTROL, 8'h00);
    // 38 running edges hold three or four ticks of twelve
    rd_get(OFS_A_LOW, v);
    chk("timer ran", 16'h1, {15'h0, v == 8'h03 || v == 8'h04});
    repeat (40) @(posedge clk);
    rd_chk(OFS_A_LOW, v, "stopped low");
    rd_chk(OFS_A_HIGH, BYTE_ZERO, "stopped high");
    $display("test run done");

    // Reload from FE gives two ticks per wrap
    wr(OFS_MODE, 8'h22);
    for (int i = 0; i < 4; i++)
      wr(OFS_A_LOW + 8'(i), 8'hFE);
    wr(OFS_CONTROL, 8'h50);
    period(0, 24);
    period(1, 24);
    wr(OFS_DIVIDER, 8'hC8);
    period(0, 8);
    period(1, 24);
    wr(OFS_DIVIDER, 8'hD0);
    period(1, 8);
    period(0, 24);
    $display("test periods done");

    // 13-bit wrap from 1FFE, then interrupt status and mask
    wr(OFS_CONTROL, 8'h00);
    wr(OFS_DIVIDER, DIVIDER_RESET);
    wr(OFS_INT_STAT, 8'h03);
    wr(OFS_MODE, 8'h00);
    wr(OFS_A_HIGH, 8'hFF);
    wr(OFS_A_LOW, 8'h1E);
    wr(OFS_CONTROL, 8'h10);
    wait_flag(0, n);
    chk("short wrap", 16'h1, {15'h0, n < 30});
    rd_chk(OFS_A_HIGH, BYTE_ZERO, "13-bit high");
    wr(OFS_CONTROL, 8'h00);
    rd_chk(OFS_INT_STAT, 8'h01, "status");
    chk("irq masked", 16'h0, {15'h0, irq});
    wr(OFS_INT_MASK, 8'h01);
    repeat (3) @(negedge clk);
    chk("irq on", 16'h1, {15'h0, irq});
    wr(OFS_INT_STAT, 8'h01);
    repeat (3) @(negedge clk);
    chk("irq cleared", 16'h0, {15'h0, irq});
    $display("test mode 0 done");

    // Split mode: high byte runs on B run, B interrupt not relied on
    wr(OFS_MODE, 8'h03);
    wr(OFS_A_LOW, BYTE_ZERO);
    wr(OFS_A_HIGH, BYTE_ONES);
    wr(OFS_CONTROL, 8'h40);
    wait_flag(1, n);
    chk("split high wrap", 16'h1, {15'h0, n < 30});
    chk("split low flag", 16'h0, {15'h0, flag_a});
    rd_chk(OFS_A_LOW, BYTE_ZERO, "split low held");
    $display("test mode 3 done");
    finish_test();
  end
endmodule : dtc_top_tb_top

`default_nettype wire
